// [cmp_regs_pkg.sv]
// Package for the comparator control and status register bank
// Assumes an APB slave with 32-bit data, one register per aligned word
package cmp_regs_pkg;

  // ---------------------------------------------------------------
  // Register indices and bus widths
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_IDX      = 4'h0;
  localparam logic [3:0] INSEL_IDX     = 4'h2;
  localparam logic [3:0] INTEN_IDX     = 4'h6;
  localparam logic [3:0] STATUS_IDX    = 4'h7;
  localparam logic [3:0] IRQMASK_IDX   = 4'h8;
  localparam logic [3:0] EVSTAT_IDX    = 4'h9;
  localparam int         ADDR_W        = 6;
  localparam int         DATA_W        = 32;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_EDGE_LO      = 4;
  localparam int CTRL_STANDBY_BIT  = 7;
  localparam int INSEL_NEG_LO      = 0;
  localparam int INSEL_POS_BIT     = 3;
  localparam int INSEL_INVERT_BIT  = 7;
  localparam int INTEN_BIT         = 0;
  localparam int STATUS_FLAG_BIT   = 0;
  localparam int STATUS_STATE_BIT  = 4;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] EDGE_ANY     = 2'h0;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_RISE    = 2'h3;
  localparam logic       POS_PIN0     = 1'h0;
  localparam logic [1:0] NEG_PIN0     = 2'h0;
  localparam logic [1:0] NEG_VREF     = 2'h2;
  localparam int         SYNC_DELAY   = 3;

  // Analog mux selection sent to the comparator
  typedef struct packed {
    logic       pos_pin0;
    logic       neg_pin0;
    logic       neg_vref;
  } mux_sel_t;

  // Event status / mask layout
  typedef struct packed {
    logic       edge_seen;
  } irq_bits_t;

endpackage

// [comparator_ctrl_status_regs.sv]
// Register bank and digital result path of the analog comparator
// Assumes an APB master on clock_i and an asynchronous comparator output
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Operation
// [RULE1] Invert bit flips result for all consumers
// [RULE2] Positive select 0 routes positive pin zero
// [RULE3] Negative select 0 pin, 2 reference
// [RULE4] Interrupt enable bit zero at 0x06
// [RULE5] State bit four shows result level
// [RULE6] State passes synchroniser, three cycle delay
// [RULE7] Writing one to flag bit clears it
// [RULE8] Edge field picks which transitions set flag
// [RULE9] Request high while flag and enable set
// [RULE10] Standby: flag and state frozen without clock
// [RULE11] Result path works only when enabled
// [RULE12] Other status writes change nothing
module comparator_ctrl_status_regs (
  input  wire logic                              clock_i,
  input  wire logic                              resetn_i,
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [cmp_regs_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [cmp_regs_pkg::DATA_W-1:0]   pwdata_i,
  input  wire logic [3:0]                        pstrb_i,
  output logic      [cmp_regs_pkg::DATA_W-1:0]   prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o,
  input  wire logic                              comparator_raw_i,
  input  wire logic                              standby_i,
  output logic                                   comparator_enable_o,
  output cmp_regs_pkg::mux_sel_t                 mux_sel_o,
  output logic                                   irq_o,
  output logic                                   event_irq_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [7:0]  insel_reg;
  logic        inten_reg;
  logic        flag_reg;
  logic        state_reg;
  logic [1:0]  sync_reg;
  logic        prev_reg;
  logic        mask_reg;
  logic        evstat_reg;

  logic [3:0]  idx;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        run;
  logic        res_in;
  logic        rise;
  logic        fall;
  logic        edge_hit;
  logic        flag_clear;
  logic [1:0]  edge_mode;

  // Word index decode from byte address
  function automatic logic [3:0] word_index(input logic [cmp_regs_pkg::ADDR_W-1:0] a);
    word_index = a[cmp_regs_pkg::ADDR_W-1:2];
  endfunction

  // Byte lane zero carries every register
  assign idx        = word_index(paddr_i);
  assign wr_en      = psel_i && penable_i && pwrite_i && pstrb_i[0];
  assign rd_en      = psel_i && penable_i && !pwrite_i;
  assign mapped     = (idx == cmp_regs_pkg::CTRL_IDX) || (idx == cmp_regs_pkg::INSEL_IDX) ||
                      (idx == cmp_regs_pkg::INTEN_IDX) || (idx == cmp_regs_pkg::STATUS_IDX) ||
                      (idx == cmp_regs_pkg::IRQMASK_IDX) || (idx == cmp_regs_pkg::EVSTAT_IDX);
  assign edge_mode  = ctrl_reg[cmp_regs_pkg::CTRL_EDGE_LO +: 2];
  // Peripheral clock stops in standby whatever the run bit says,
  // so flag and state freeze there; the run bit only keeps the comparator on
  assign run        = ctrl_reg[cmp_regs_pkg::CTRL_ENABLE_BIT] &&                        // [RULE11]
                      !standby_i;                                                       // [RULE10]
  // Inversion applied before every consumer of the result
  assign res_in     = sync_reg[1] ^ insel_reg[cmp_regs_pkg::INSEL_INVERT_BIT];         // [RULE1]
  assign rise       = res_in && !prev_reg;
  assign fall       = !res_in && prev_reg;
  // Reserved code 0x1 never sets the flag
  always_comb begin
    unique case (edge_mode)
      cmp_regs_pkg::EDGE_ANY:  edge_hit = rise || fall;                                // [RULE8]
      cmp_regs_pkg::EDGE_FALL: edge_hit = fall;                                        // [RULE8]
      cmp_regs_pkg::EDGE_RISE: edge_hit = rise;                                        // [RULE8]
      default:                 edge_hit = 1'b0;
    endcase
  end
  assign flag_clear = wr_en && (idx == cmp_regs_pkg::STATUS_IDX) &&
                      pwdata_i[cmp_regs_pkg::STATUS_FLAG_BIT];                          // [RULE7]

  // ---------------------------------------------------------------
  // Software written control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg  <= cmp_regs_pkg::REG_RESET;
      insel_reg <= cmp_regs_pkg::REG_RESET;
      inten_reg <= 1'b0;
      mask_reg  <= 1'b0;
    end else if (wr_en) begin
      unique case (idx)
        cmp_regs_pkg::CTRL_IDX:    ctrl_reg  <= pwdata_i[7:0];
        cmp_regs_pkg::INSEL_IDX:   insel_reg <= pwdata_i[7:0];
        cmp_regs_pkg::INTEN_IDX:   inten_reg <= pwdata_i[cmp_regs_pkg::INTEN_BIT];    // [RULE4]
        cmp_regs_pkg::IRQMASK_IDX: mask_reg  <= pwdata_i[0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Synchroniser and edge history
  // ---------------------------------------------------------------
  // Two flops resynchronise; the state bit itself is the third stage
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], comparator_raw_i};                                       // [RULE6]
    end
  end

  // State and edge history freeze when the path is not running
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else if (run) begin
      state_reg <= res_in;                                                              // [RULE5] [RULE6]
      prev_reg  <= res_in;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flag
  // ---------------------------------------------------------------
  // An edge in the clearing cycle wins so no event is lost
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
    end else if (run && edge_hit) begin
      flag_reg <= 1'b1;                                                                 // [RULE8]
    end else if (flag_clear) begin
      flag_reg <= 1'b0;                                                                 // [RULE7] [RULE12]
    end
  end

  // Sticky event copy, cleared by reading it
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evstat_reg <= 1'b0;
    end else if (run && edge_hit) begin
      evstat_reg <= 1'b1;
    end else if (rd_en && pready_o && idx == cmp_regs_pkg::EVSTAT_IDX) begin
      evstat_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o               <= 1'b0;
      event_irq_o         <= 1'b0;
      comparator_enable_o <= 1'b0;
      mux_sel_o           <= '0;
    end else begin
      irq_o               <= flag_reg && inten_reg;                                    // [RULE9]
      event_irq_o         <= evstat_reg && mask_reg;
      // Without the run bit the comparator is switched off in standby
      comparator_enable_o <= ctrl_reg[cmp_regs_pkg::CTRL_ENABLE_BIT] &&                  // [RULE11]
                             (!standby_i || ctrl_reg[cmp_regs_pkg::CTRL_STANDBY_BIT]);   // [RULE10]
      // Reserved codes drive no input at all
      mux_sel_o.pos_pin0  <= insel_reg[cmp_regs_pkg::INSEL_POS_BIT] == cmp_regs_pkg::POS_PIN0; // [RULE2]
      mux_sel_o.neg_pin0  <= insel_reg[cmp_regs_pkg::INSEL_NEG_LO +: 2] == cmp_regs_pkg::NEG_PIN0; // [RULE3]
      mux_sel_o.neg_vref  <= insel_reg[cmp_regs_pkg::INSEL_NEG_LO +: 2] == cmp_regs_pkg::NEG_VREF; // [RULE3]
    end
  end

  // ---------------------------------------------------------------
  // APB answer: no wait state, so every access takes two cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o       <= 1'b0;
      pslverr_o      <= 1'b0;
      prdata_o       <= '0;
    end else begin
      pready_o       <= psel_i && !penable_i;
      pslverr_o      <= psel_i && !penable_i && !mapped;
      if (psel_i && !penable_i && !pwrite_i) begin
        unique case (idx)
          cmp_regs_pkg::CTRL_IDX:    prdata_o <= {24'h0, ctrl_reg};
          cmp_regs_pkg::INSEL_IDX:   prdata_o <= {24'h0, insel_reg};
          cmp_regs_pkg::INTEN_IDX:   prdata_o <= {31'h0, inten_reg};
          cmp_regs_pkg::STATUS_IDX:  prdata_o <= {27'h0, state_reg, 3'h0, flag_reg};   // [RULE5]
          cmp_regs_pkg::IRQMASK_IDX: prdata_o <= {31'h0, mask_reg};
          cmp_regs_pkg::EVSTAT_IDX:  prdata_o <= {31'h0, evstat_reg};
          default:                   prdata_o <= '0;
        endcase
      end else begin
        prdata_o <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  irq_follows_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE9]
    ##1 irq_o == $past(flag_reg && inten_reg))
    else $error("irq not following flag and enable");

  flag_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE7]
    flag_clear && !(run && edge_hit) |=> !flag_reg)
    else $error("flag not cleared by write one");

  flag_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE12]
    !flag_clear && !(run && edge_hit) |=> flag_reg == $past(flag_reg))
    else $error("flag changed without cause");

  rise_sets_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE8]
    run && rise && edge_mode == cmp_regs_pkg::EDGE_RISE |=> flag_reg)
    else $error("rising edge did not set flag");

  fall_only_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE8]
    !flag_reg && run && rise && !fall && edge_mode == cmp_regs_pkg::EDGE_FALL && !flag_clear |=> !flag_reg)
    else $error("rising edge set flag in falling mode");

  state_delay_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE6]
    run ##1 run ##1 run |->
      state_reg == ($past(comparator_raw_i, cmp_regs_pkg::SYNC_DELAY) ^
                    $past(insel_reg[cmp_regs_pkg::INSEL_INVERT_BIT], 1)))
    else $error("state bit not three cycles behind input");

  disabled_freeze_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE11]
    !ctrl_reg[cmp_regs_pkg::CTRL_ENABLE_BIT] |=> $stable(state_reg) && !$rose(flag_reg))
    else $error("result path active while disabled");

  standby_freeze_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE10]
    standby_i && ctrl_reg[cmp_regs_pkg::CTRL_STANDBY_BIT] |=> $stable(state_reg))
    else $error("state updated in standby");

  mux_vref_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE3]
    insel_reg[cmp_regs_pkg::INSEL_NEG_LO +: 2] == cmp_regs_pkg::NEG_VREF |=> mux_sel_o.neg_vref && !mux_sel_o.neg_pin0)
    else $error("reference not selected");

  mux_pos_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE2]
    insel_reg[cmp_regs_pkg::INSEL_POS_BIT] |=> !mux_sel_o.pos_pin0)
    else $error("reserved positive code drove a pin");

  // ---------------------------------------------------------------
  // Register and result path checks
  // ---------------------------------------------------------------
  neg_reserved_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE3]
    insel_reg[cmp_regs_pkg::INSEL_NEG_LO] |=> !mux_sel_o.neg_pin0 && !mux_sel_o.neg_vref)
    else $error("reserved negative code drove an input");

  inten_write_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE4]
    wr_en && idx == cmp_regs_pkg::INTEN_IDX |=> inten_reg == $past(pwdata_i[cmp_regs_pkg::INTEN_BIT]))
    else $error("interrupt enable write lost");

  invert_path_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE1]
    run |=> state_reg == ($past(sync_reg[1]) ^ $past(insel_reg[cmp_regs_pkg::INSEL_INVERT_BIT])))
    else $error("state bit not the inverted result");

  irq_held_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE9]
    flag_reg && inten_reg |=> irq_o)
    else $error("request dropped while flag set");

  standby_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE10]
    standby_i |=> !$rose(flag_reg))
    else $error("flag set in standby");

  standby_cmp_off_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE10]
    standby_i && !ctrl_reg[cmp_regs_pkg::CTRL_STANDBY_BIT] |=> !comparator_enable_o)
    else $error("comparator left on in standby");

  event_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    rd_en && pready_o && idx == cmp_regs_pkg::EVSTAT_IDX && !(run && edge_hit) |=> !evstat_reg)
    else $error("event status not cleared by read");

  // ---------------------------------------------------------------
  // Bus answer checks
  // ---------------------------------------------------------------
  pready_pulse_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");

  unmapped_error_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    psel_i && !penable_i && !mapped |=> pready_o && pslverr_o)
    else $error("unmapped access without error");

  mapped_ok_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    psel_i && !penable_i && mapped |=> pready_o && !pslverr_o)
    else $error("mapped access answered wrongly");

  status_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // [RULE5]
    psel_i && !penable_i && !pwrite_i && idx == cmp_regs_pkg::STATUS_IDX |=>
      prdata_o[cmp_regs_pkg::STATUS_STATE_BIT] == $past(state_reg) &&
      prdata_o[cmp_regs_pkg::STATUS_FLAG_BIT] == $past(flag_reg))
    else $error("status read data wrong");

endmodule

// [comparator_output_model.sv]
// Behavioural stand-in for the analog comparator output
// Assumes the bench sets the wanted level; output is asynchronous to clock_i
`timescale 1ns/1ps
module comparator_output_model (
  input  wire logic level_i,
  output logic      raw_o
);
  // Propagation delay keeps edges off the clock grid, like a real comparator
  initial begin
    raw_o = 1'b0;
    forever begin
      @(level_i);
      raw_o <= #7 level_i;
    end
  end
endmodule

// [comparator_ctrl_status_regs_test.sv]
// Self-checking bench for the comparator register bank
// Assumes a 40 MHz clock and an APB master written as tasks below
`timescale 1ns/1ps
module comparator_ctrl_status_regs_test;
  typedef struct {logic [7:0] d; logic [2:0] m;} row_t;
  logic        clock_i, resetn_i, psel_i, penable_i, pwrite_i, standby_i, lvl, raw;
  logic [5:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic [3:0]  pstrb_i;
  logic        pready_o, pslverr_o, comparator_enable_o, irq_o, event_irq_o, e;
  cmp_regs_pkg::mux_sel_t mux_sel_o;
  int          fails, total_checks;
  row_t        rows[6];
  logic [1:0]  modes[3];
  comparator_ctrl_status_regs comparator_ctrl_status_regs_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .comparator_raw_i(raw), .standby_i(standby_i), .comparator_enable_o(comparator_enable_o),
    .mux_sel_o(mux_sel_o), .irq_o(irq_o), .event_irq_o(event_irq_o));
  comparator_output_model comparator_output_model_i (.level_i(lvl), .raw_o(raw));
  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [5:0] ad(input logic [3:0] i);
    return {i, 2'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = prdata_o; e = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, ad(i), {24'h0, d});
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] x);
    apb(1'b0, ad(i), 32'h0);
    chk(q, {24'h0, x});
  endtask
  // Sync chain is three stages; extra margin for edge and flag registers
  task automatic settle();
    repeat (cmp_regs_pkg::SYNC_DELAY + 4) @(posedge clock_i);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: whole run is well under a few thousand cycles
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    psel_i = 0; penable_i = 0; pwrite_i = 0; paddr_i = 6'h00; pwdata_i = 32'h0;
    pstrb_i = 4'hF; standby_i = 0; lvl = 0; resetn_i = 0; fails = 0; total_checks = 0;
    rows = '{'{8'h00, 3'h6}, '{8'h02, 3'h5}, '{8'h01, 3'h4}, '{8'h08, 3'h2}, '{8'h0B, 3'h0}, '{8'h80, 3'h6}};
    modes = '{cmp_regs_pkg::EDGE_ANY, cmp_regs_pkg::EDGE_FALL, cmp_regs_pkg::EDGE_RISE};
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      wr(cmp_regs_pkg::INSEL_IDX, rows[r].d);
      rd(cmp_regs_pkg::INSEL_IDX, rows[r].d);
      chk(32'(mux_sel_o), 32'(rows[r].m));
    end
    $display("mux table done");
    wr(cmp_regs_pkg::INSEL_IDX, 8'h00);
    wr(cmp_regs_pkg::INTEN_IDX, 8'h01);
    rd(cmp_regs_pkg::INTEN_IDX, 8'h01);
    // Lane zero strobe low: the write must be dropped
    pstrb_i <= 4'hE;
    wr(cmp_regs_pkg::INTEN_IDX, 8'h00);
    pstrb_i <= 4'hF;
    rd(cmp_regs_pkg::INTEN_IDX, 8'h01);
    wr(cmp_regs_pkg::IRQMASK_IDX, 8'h01);
    apb(1'b0, 6'h3C, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(cmp_regs_pkg::CTRL_IDX, {2'h0, modes[i], 4'h1});
      wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
      lvl <= 1'b1;
      settle();
      rd(cmp_regs_pkg::STATUS_IDX, {7'h08, modes[i] != cmp_regs_pkg::EDGE_FALL});
      if (i == 0) begin
        chk(32'(irq_o), 32'h1);
        chk(32'(event_irq_o), 32'h1);
        rd(cmp_regs_pkg::EVSTAT_IDX, 8'h01);
        rd(cmp_regs_pkg::EVSTAT_IDX, 8'h00);
        chk(32'(event_irq_o), 32'h0);
        wr(cmp_regs_pkg::STATUS_IDX, 8'h10);
        rd(cmp_regs_pkg::STATUS_IDX, 8'h11);
        wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
        rd(cmp_regs_pkg::STATUS_IDX, 8'h10);
        chk(32'(irq_o), 32'h0);
      end
      wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
      lvl <= 1'b0;
      settle();
      rd(cmp_regs_pkg::STATUS_IDX, {7'h00, modes[i] != cmp_regs_pkg::EDGE_RISE});
    end
    // Reserved edge code sets the flag on neither edge
    wr(cmp_regs_pkg::CTRL_IDX, 8'h11);
    wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
    lvl <= 1'b1;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h10);
    lvl <= 1'b0;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h00);
    $display("edge modes done");
    // Disabled path: state and flag hold while the input moves
    wr(cmp_regs_pkg::CTRL_IDX, 8'h00);
    wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
    chk(32'(comparator_enable_o), 32'h0);
    lvl <= 1'b1;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h00);
    lvl <= 1'b0;
    settle();
    // Standby with run bit set: status frozen until the clock returns
    wr(cmp_regs_pkg::CTRL_IDX, 8'h81);
    standby_i <= 1'b1;
    lvl <= 1'b1;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h00);
    chk(32'(comparator_enable_o), 32'h1);
    standby_i <= 1'b0;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h11);
    $display("enable and standby done");
    // Standby without the run bit: path halted and comparator off
    wr(cmp_regs_pkg::CTRL_IDX, 8'h01);
    standby_i <= 1'b1;
    lvl <= 1'b0;
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h11);
    chk(32'(comparator_enable_o), 32'h0);
    standby_i <= 1'b0;
    // Inversion: low input reads high and raises the flag; event masked
    wr(cmp_regs_pkg::CTRL_IDX, 8'h01);
    lvl <= 1'b0;
    settle();
    wr(cmp_regs_pkg::IRQMASK_IDX, 8'h00);
    rd(cmp_regs_pkg::EVSTAT_IDX, 8'h01);
    wr(cmp_regs_pkg::STATUS_IDX, 8'h01);
    wr(cmp_regs_pkg::INSEL_IDX, 8'h80);
    settle();
    rd(cmp_regs_pkg::STATUS_IDX, 8'h11);
    chk(32'(event_irq_o), 32'h0);
    $display("invert done");
    // Mid-run reset returns every register to zero
    resetn_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(cmp_regs_pkg::CTRL_IDX, 8'h00);
    rd(cmp_regs_pkg::INSEL_IDX, 8'h00);
    rd(cmp_regs_pkg::INTEN_IDX, 8'h00);
    rd(cmp_regs_pkg::STATUS_IDX, 8'h00);
    chk(32'(irq_o), 32'h0);
    $display("reset done");
    give_verdict();
  end
endmodule
